// ===== design/amr_defines.vh
// Purpose: constants for the measurement readback bank
// Assumes: 8-bit register bus, 10-bit converter results
// Notes: offsets are register addresses on the device register port
`ifndef AMR_DEFINES_VH
`define AMR_DEFINES_VH
`define AMR_ADDR_LED_VOLTAGE_CH1 8'h14
`define AMR_ADDR_LED_VOLTAGE_ON_CH1 8'h15
`define AMR_ADDR_LED_VOLTAGE_OFF_CH1 8'h16
`define AMR_ADDR_INPUT_VOLTAGE_CH2 8'h17
`define AMR_ADDR_LED_VOLTAGE_CH2 8'h18
`define AMR_ADDR_LED_VOLTAGE_ON_CH2 8'h19
`define AMR_ADDR_LED_VOLTAGE_OFF_CH2 8'h1A
`define AMR_ADDR_JUNCTION_TEMP_LOW 8'h1B
`define AMR_ADDR_JUNCTION_TEMP_HIGH 8'h1C
`define AMR_ADDR_BIAS_SUPPLY_VOLTAGE 8'h1D
`define AMR_RESET_VALUE 8'h00
`define AMR_RESULT_MSB 9
`define AMR_RESULT_LSB 2
`define AMR_TEMP_LOW_MSB 1
`define AMR_SRC_LED1 3'h0
`define AMR_SRC_DRAIN2 3'h1
`define AMR_SRC_LED2 3'h2
`define AMR_SRC_TEMP 3'h3
`define AMR_SRC_BIAS 3'h4
`endif

// ===== design/amr_edge_sampler.v
// Purpose: holds the last sense-node result seen before each PWM edge
// Assumes: dimming PWM arrives from outside the clock domain
// Notes: one instance per channel
`timescale 1ns/1ps
module amr_edge_sampler #(
	parameter WIDTH = 8
) (
	input wire clk_i,
	input wire resetn_i,
	input wire pwm_i,
	input wire [WIDTH-1:0] sense_i,
	output reg [WIDTH-1:0] before_fall_o,
	output reg [WIDTH-1:0] before_rise_o
);
reg pwm_meta_q;
reg pwm_sync_q;
reg pwm_prev_q;
// =====================================
// Synchroniser and edge capture
// Sense value is the one stored before the edge was seen, so it
// can postdate the transition by up to the sync latency.
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		pwm_meta_q <= 1'b0;
		pwm_sync_q <= 1'b0;
		pwm_prev_q <= 1'b0;
		before_fall_o <= {WIDTH{1'b0}};
		before_rise_o <= {WIDTH{1'b0}};
	end
	else
	begin
		pwm_meta_q <= pwm_i;
		pwm_sync_q <= pwm_meta_q;
		pwm_prev_q <= pwm_sync_q;
		if (pwm_prev_q && !pwm_sync_q)
			before_fall_o <= sense_i;
		if (!pwm_prev_q && pwm_sync_q)
			before_rise_o <= sense_i;
	end
end
endmodule

// ===== design/amr_readback.v
// Purpose: read-only bank of converter measurement results
// Assumes: converter delivers 10-bit results with a one-cycle valid
// Notes: register port is a plain address/read strobe, one-cycle reply
// Notes on behaviour
// - Address 0x14 reads channel 1 sense node, 65/255 V per code.
// - Address 0x15 holds channel 1 sense node before PWM falling edge.
// - Address 0x16 holds channel 1 sense node before PWM rising edge.
// - Address 0x17 reads channel 2 drain voltage, 65 V full scale.
// - Address 0x18 reads channel 2 sense node, 65/255 V per code.
// - Address 0x19 holds channel 2 sense node before PWM falling edge.
// - Address 0x1A holds channel 2 sense node before PWM rising edge.
// - Address 0x1B bits 1-0 hold temperature LSBs, rest reserved.
// - Address 0x1C holds temperature upper eight bits, resets to zero.
// - Address 0x1D reads 5 V bias supply, 5.33/255 V per code.
// - All registers read-only; writes change nothing.
// - Voltage registers keep the eight MSBs of the 10-bit result.
`timescale 1ns/1ps
`include "amr_defines.vh"
module amr_readback #(
	parameter ADC_WIDTH = 10
) (
	input wire clk_i,
	input wire resetn_i,
	input wire adc_valid_i,
	input wire [2:0] adc_source_i,
	input wire [ADC_WIDTH-1:0] adc_result_i,
	input wire pwm_ch1_i,
	input wire pwm_ch2_i,
	input wire reg_read_i,
	input wire reg_write_i,
	input wire [7:0] reg_addr_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_rvalid_o,
	output reg reg_error_o
);
reg [7:0] led_voltage_ch1_q;
reg [7:0] input_voltage_ch2_q;
reg [7:0] led_voltage_ch2_q;
reg [1:0] temp_low_q;
reg [7:0] junction_temp_high_q;
reg [7:0] bias_supply_voltage_q;
wire [7:0] on_ch1;
wire [7:0] off_ch1;
wire [7:0] on_ch2;
wire [7:0] off_ch2;
wire [7:0] adc_top;
wire [1:0] adc_low;
wire take_led1;
wire take_drain2;
wire take_led2;
wire take_temp;
wire take_bias;
reg [7:0] rdata_d;
reg hit_d;
reg error_d;
assign adc_top = adc_result_i[`AMR_RESULT_MSB:`AMR_RESULT_LSB];
assign adc_low = adc_result_i[`AMR_TEMP_LOW_MSB:0];

// =====================================
// Source decode
// Unused source codes strobe nothing, so they cannot disturb the bank.
assign take_led1 = adc_valid_i && (adc_source_i == `AMR_SRC_LED1);
assign take_drain2 = adc_valid_i && (adc_source_i == `AMR_SRC_DRAIN2);
assign take_led2 = adc_valid_i && (adc_source_i == `AMR_SRC_LED2);
assign take_temp = adc_valid_i && (adc_source_i == `AMR_SRC_TEMP);
assign take_bias = adc_valid_i && (adc_source_i == `AMR_SRC_BIAS);

// =====================================
// Channel 1 sense node
// Whole result lands in one edge, so a read sees old or new, never a mix.
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		led_voltage_ch1_q <= `AMR_RESET_VALUE;
	end
	else if (take_led1)
	begin
		led_voltage_ch1_q <= adc_top;
	end
end

// =====================================
// Channel 2 drain
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		input_voltage_ch2_q <= `AMR_RESET_VALUE;
	end
	else if (take_drain2)
	begin
		input_voltage_ch2_q <= adc_top;
	end
end

// =====================================
// Channel 2 sense node
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		led_voltage_ch2_q <= `AMR_RESET_VALUE;
	end
	else if (take_led2)
	begin
		led_voltage_ch2_q <= adc_top;
	end
end

// =====================================
// Junction temperature
// Both halves come from one result on one edge, so the pair stays matched.
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		temp_low_q <= 2'h0;
		junction_temp_high_q <= `AMR_RESET_VALUE;
	end
	else if (take_temp)
	begin
		temp_low_q <= adc_low;
		junction_temp_high_q <= adc_top;
	end
end

// =====================================
// Bias supply
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		bias_supply_voltage_q <= `AMR_RESET_VALUE;
	end
	else if (take_bias)
	begin
		bias_supply_voltage_q <= adc_top;
	end
end

// =====================================
// Edge samplers
// Fed from the stored result, so each sample is the last result stored before its PWM edge is detected.
amr_edge_sampler #(.WIDTH(8)) u_ch1 (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.pwm_i(pwm_ch1_i),
	.sense_i(led_voltage_ch1_q),
	.before_fall_o(on_ch1),
	.before_rise_o(off_ch1)
);
amr_edge_sampler #(.WIDTH(8)) u_ch2 (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.pwm_i(pwm_ch2_i),
	.sense_i(led_voltage_ch2_q),
	.before_fall_o(on_ch2),
	.before_rise_o(off_ch2)
);

// =====================================
// Read decode
// Unmapped addresses read zero and flag an error.
always @*
begin
	rdata_d = 8'h00;
	hit_d = 1'b1;
	case (reg_addr_i)
	`AMR_ADDR_LED_VOLTAGE_CH1: rdata_d = led_voltage_ch1_q;
	`AMR_ADDR_LED_VOLTAGE_ON_CH1: rdata_d = on_ch1;
	`AMR_ADDR_LED_VOLTAGE_OFF_CH1: rdata_d = off_ch1;
	`AMR_ADDR_INPUT_VOLTAGE_CH2: rdata_d = input_voltage_ch2_q;
	`AMR_ADDR_LED_VOLTAGE_CH2: rdata_d = led_voltage_ch2_q;
	`AMR_ADDR_LED_VOLTAGE_ON_CH2: rdata_d = on_ch2;
	`AMR_ADDR_LED_VOLTAGE_OFF_CH2: rdata_d = off_ch2;
	`AMR_ADDR_JUNCTION_TEMP_LOW: rdata_d = {6'h00, temp_low_q};
	`AMR_ADDR_JUNCTION_TEMP_HIGH: rdata_d = junction_temp_high_q;
	`AMR_ADDR_BIAS_SUPPLY_VOLTAGE: rdata_d = bias_supply_voltage_q;
	default: hit_d = 1'b0;
	endcase
end

// =====================================
// Reply flags
// Writes never touch the bank; they only draw an error pulse.
always @*
begin
	error_d = reg_write_i;
	if (reg_read_i && !hit_d)
	begin
		error_d = 1'b1;
	end
end
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		reg_rvalid_o <= 1'b0;
		reg_error_o <= 1'b0;
	end
	else
	begin
		reg_rvalid_o <= reg_read_i;
		reg_error_o <= error_d;
	end
end

// =====================================
// Read data
// Zero outside a reply, so stale data is never mistaken for a result.
always @(posedge clk_i or negedge resetn_i)
begin
	if (!resetn_i)
	begin
		reg_rdata_o <= 8'h00;
	end
	else if (reg_read_i)
	begin
		reg_rdata_o <= rdata_d;
	end
	else
	begin
		reg_rdata_o <= 8'h00;
	end
end
endmodule

// ===== testbench/amr_readback_props.sv
// Purpose: port checker for the readback bank
// Assumes: one-cycle registered reply
// Notes: bound from the bench top
`timescale 1ns/1ps
module amr_readback_props #(
	parameter ADC_WIDTH = 10
) (
	input wire clk_i,
	input wire resetn_i,
	input wire adc_valid_i,
	input wire [2:0] adc_source_i,
	input wire [ADC_WIDTH-1:0] adc_result_i,
	input wire reg_read_i,
	input wire reg_write_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_rdata_o,
	input wire reg_rvalid_o,
	input wire reg_error_o
);
// ====
// Port relations
default clocking @(posedge clk_i); endclocking
default disable iff (!resetn_i);
wire map = reg_addr_i >= 8'h14 && reg_addr_i <= 8'h1D;
a_read_reply: assert property (reg_read_i |=> reg_rvalid_o)
	else $error("no reply");
a_no_stray: assert property (!reg_read_i |=> !reg_rvalid_o)
	else $error("stray reply");
a_write_refused: assert property (reg_write_i |=> reg_error_o)
	else $error("write taken");
a_unmapped_read: assert property (reg_read_i && !map |=>
	reg_error_o && reg_rdata_o == 8'h00) else $error("unmapped");
a_mapped_clean: assert property (reg_read_i && !reg_write_i && map
	|=> !reg_error_o) else $error("false error");
a_temp_reserved: assert property (reg_read_i && reg_addr_i == 8'h1B
	|=> reg_rdata_o[7:2] == 6'h00) else $error("reserved bits");
a_ch1_msbs: assert property (adc_valid_i && adc_source_i == 3'h0
	##1 !adc_valid_i ##1 reg_read_i && !adc_valid_i
	&& reg_addr_i == 8'h14
	|=> reg_rdata_o == $past(adc_result_i[9:2], 3)) else $error("ch1");
a_bias_msbs: assert property (adc_valid_i && adc_source_i == 3'h4
	##1 !adc_valid_i ##1 reg_read_i && !adc_valid_i
	&& reg_addr_i == 8'h1D
	|=> reg_rdata_o == $past(adc_result_i[9:2], 3)) else $error("bias");
endmodule

// ===== testbench/amr_host.sv
// Purpose: host model issuing register requests
// Assumes: reply lands one edge after the request
// Notes: address is inverted once released
`timescale 1ns/1ps
module amr_host (
	input wire clk_i,
	output reg rd_o = 1'b0,
	output reg wr_o = 1'b0,
	output reg [7:0] addr_o = 8'h00
);
task xfer(input logic w, input logic [7:0] a);
begin
	@(posedge clk_i);
	rd_o <= !w;
	wr_o <= w;
	addr_o <= a;
	@(posedge clk_i);
	rd_o <= 1'b0;
	wr_o <= 1'b0;
	addr_o <= ~a;
	#1;
end
endtask
endmodule

// ===== testbench/amr_readback_tb_top.sv
// Purpose: self-checking bench for the readback bank
// Assumes: PWM edges land within four cycles
// Notes: all waits are fixed counts
`timescale 1ns/1ps
module amr_readback_tb_top;
reg clk_i = 1'b0;
reg resetn_i = 1'b0;
reg adc_valid_i = 1'b0;
reg [2:0] adc_source_i = 3'h0;
reg [9:0] adc_result_i = 10'h000;
reg pwm_ch1_i = 1'b0;
reg pwm_ch2_i = 1'b0;
wire reg_read_i, reg_write_i, reg_rvalid_o, reg_error_o;
wire [7:0] reg_addr_i, reg_rdata_o;
integer n_errors = 0;
integer num_checks = 0;
integer i;
always #2.5 clk_i = ~clk_i;
amr_host amr_host_i (.clk_i, .rd_o(reg_read_i), .wr_o(reg_write_i),
	.addr_o(reg_addr_i));
amr_readback amr_readback_i (.clk_i, .resetn_i, .adc_valid_i,
	.adc_source_i, .adc_result_i, .pwm_ch1_i, .pwm_ch2_i, .reg_read_i,
	.reg_write_i, .reg_addr_i, .reg_rdata_o, .reg_rvalid_o, .reg_error_o);
// ====
// Tasks
task chk(input logic [7:0] s, input logic [7:0] e);
begin
	num_checks = num_checks + 1;
	if (s !== e)
	begin
		n_errors = n_errors + 1;
		$display("CHECK FAILED %0t got %h want %h", $time, s, e);
	end
end
endtask
task rd(input logic [7:0] a, input logic [7:0] e, input logic ee);
begin
	amr_host_i.xfer(1'b0, a);
	chk(reg_rdata_o, e);
	chk({7'h00, reg_error_o}, {7'h00, ee});
	chk({7'h00, reg_rvalid_o}, 8'h01);
	@(posedge clk_i);
	#1;
	chk({7'h00, reg_rvalid_o}, 8'h00);
	chk(reg_rdata_o, 8'h00);
end
endtask
task adc(input logic [2:0] s, input logic [9:0] v);
begin
	@(posedge clk_i);
	adc_valid_i <= 1'b1;
	adc_source_i <= s;
	adc_result_i <= v;
	@(posedge clk_i);
	adc_valid_i <= 1'b0;
	adc_result_i <= ~v;
end
endtask
task pwm(input logic v);
begin
	@(posedge clk_i);
	pwm_ch1_i <= v;
	pwm_ch2_i <= v;
	repeat (4) @(posedge clk_i);
end
endtask
task complete_run;
begin
	$display("checks %0d errors %0d", num_checks, n_errors);
	if (n_errors == 0 && num_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
end
endtask
// ====
// Sequence
initial
begin
	repeat (4) @(posedge clk_i);
	resetn_i <= 1'b1;
	for (i = 8'h14; i <= 8'h1D; i = i + 1)
		rd(i[7:0], 8'h00, 1'b0);
	adc(3'h0, 10'h3FF);
	adc(3'h1, 10'h155);
	adc(3'h2, 10'h2A6);
	adc(3'h3, 10'h2B7);
	adc(3'h4, 10'h0C8);
	rd(8'h1D, 8'h32, 1'b0);
	rd(8'h14, 8'hFF, 1'b0);
	rd(8'h17, 8'h55, 1'b0);
	rd(8'h18, 8'hA9, 1'b0);
	rd(8'h1B, 8'h03, 1'b0);
	rd(8'h1C, 8'hAD, 1'b0);
	rd(8'h1D, 8'h32, 1'b0);
	pwm(1'b1);
	rd(8'h16, 8'hFF, 1'b0);
	rd(8'h1A, 8'hA9, 1'b0);
	adc(3'h0, 10'h100);
	rd(8'h14, 8'h40, 1'b0);
	adc(3'h2, 10'h080);
	pwm(1'b0);
	rd(8'h15, 8'h40, 1'b0);
	rd(8'h19, 8'h20, 1'b0);
	amr_host_i.xfer(1'b1, 8'h14);
	chk({7'h00, reg_error_o}, 8'h01);
	chk({7'h00, reg_rvalid_o}, 8'h00);
	adc(3'h7, 10'h3FF);
	rd(8'h14, 8'h40, 1'b0);
	rd(8'h1D, 8'h32, 1'b0);
	rd(8'h14, 8'h40, 1'b0);
	rd(8'h1E, 8'h00, 1'b1);
	@(posedge clk_i);
	resetn_i <= 1'b0;
	repeat (2) @(posedge clk_i);
	resetn_i <= 1'b1;
	rd(8'h1C, 8'h00, 1'b0);
	rd(8'h15, 8'h00, 1'b0);
	complete_run;
end
endmodule
bind amr_readback amr_readback_props #(.ADC_WIDTH(ADC_WIDTH))
	amr_readback_props_i (.clk_i, .resetn_i, .adc_valid_i, .adc_source_i,
	.adc_result_i, .reg_read_i, .reg_write_i, .reg_addr_i, .reg_rdata_o,
	.reg_rvalid_o, .reg_error_o);
